//--- asc_pkg.sv
// package: constants, types and timing for the sample and convert controller
package asc_pkg;

	// clock and timing figures
	localparam int unsigned CLK_PERIOD_NS  = 50;     // hclk period at 20 MHz
	localparam int unsigned CONV_TIME_NS   = 3860;   // longest oscillator conversion
	localparam int unsigned FIRST_SAMPLE_NS = 2000;  // time a first repeat sample needs

	// counter width shared by sampling and conversion counts
	localparam int unsigned CNT_W = 8;

	// longest time rounds down, least time rounds up
	localparam logic [CNT_W-1:0] CONV_OSC_CYCLES = CNT_W'(CONV_TIME_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FIRST_CYCLES    = CNT_W'((FIRST_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// serial framing
	localparam logic [2:0] CMD_BITS     = 3'h4;   // command nibble length
	localparam int unsigned SHIFT_W     = 16;     // serial output word
	localparam int unsigned RESULT_W    = 10;     // converter result width
	localparam logic [CNT_W-1:0] SHORT_SCLKS = 8'h0c;  // 12 sclk short sampling
	localparam logic [CNT_W-1:0] LONG_SCLKS  = 8'h18;  // 24 sclk long sampling
	localparam logic [CNT_W-1:0] CONV_SCLKS  = 8'h0e;  // 14 divided clocks per conversion

	// command nibbles
	localparam logic [3:0] CMD_CHAN_LAST  = 4'h7;
	localparam logic [3:0] CMD_POWER_DOWN = 4'h8;
	localparam logic [3:0] CMD_READ_CFG   = 4'h9;
	localparam logic [3:0] CMD_TEST_FIRST = 4'hb;
	localparam logic [3:0] CMD_TEST_LAST  = 4'hd;
	localparam logic [3:0] CMD_READ_FIFO  = 4'he;

	// conversion modes and clock sources
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] CLK_OSC     = 2'h0;
	localparam logic [1:0] CLK_SCLK    = 2'h1;
	localparam logic [1:0] CLK_DIV4    = 2'h2;
	localparam logic [1:0] CLK_DIV2    = 2'h3;

	// register byte offsets
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_CMD    = 8'h0c;
	localparam logic [11:0] CFG_RESET  = 12'h000;

	// status field positions
	localparam int unsigned ST_BUSY_BIT  = 8;
	localparam int unsigned ST_PD_BIT    = 9;
	localparam int unsigned ST_EXT_BIT   = 10;
	localparam int unsigned ST_VALID_BIT = 11;

	// configuration register, bit 11 down to bit 0
	typedef struct packed {
		logic       ref_internal;
		logic       ref_2v;
		logic       long_sample;
		logic [1:0] conv_clk;
		logic [1:0] conv_mode;
		logic [1:0] sweep_seq;
		logic       eoc_select;
		logic [1:0] fifo_level;
	} asc_cfg_s;

	// serial pins from the host
	typedef struct packed {
		logic sclk;
		logic chip_select_n;
		logic frame_sync;
		logic serial_in;
		logic sample_trigger_n;
	} asc_pins_s;

	// controller states, one hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_CMD    = 6'h02,
		ST_SAMP_N = 6'h04,
		ST_SAMP_X = 6'h08,
		ST_SAMP_F = 6'h10,
		ST_CONV   = 6'h20
	} asc_state_e;

endpackage

//--- asc_top.sv
// module: sample and conversion control of a serial converter with an ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
module asc_top #(
	parameter int unsigned RESULT_W = asc_pkg::RESULT_W
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire asc_pkg::asc_pins_s  pins,
	input  wire logic [RESULT_W-1:0] conv_data,
	output logic                     serial_out,
	output logic                     conversion_busy_flag,
	output logic                     done_interrupt_n,
	output logic                     sample_hold,
	output logic                     result_push,
	output logic [RESULT_W-1:0]      result_data,
	output logic                     powered_down
);
	import asc_pkg::*;

	// true for channel and test select nibbles
	function automatic logic is_conv_cmd(input logic [3:0] c);
		is_conv_cmd = (c <= CMD_CHAN_LAST) || ((c >= CMD_TEST_FIRST) && (c <= CMD_TEST_LAST));
	endfunction

	// sclk count of a normal sampling period
	function automatic logic [CNT_W-1:0] samp_len(input logic long_sel);
		samp_len = long_sel ? LONG_SCLKS : SHORT_SCLKS;
	endfunction

	// sclk edges needed for one conversion at the chosen divider
	function automatic logic [CNT_W-1:0] conv_edges(input logic [1:0] sel);
		case (sel)
			CLK_DIV4: conv_edges = CNT_W'(CONV_SCLKS * 4);
			CLK_DIV2: conv_edges = CNT_W'(CONV_SCLKS * 2);
			default:  conv_edges = CONV_SCLKS;
		endcase
	endfunction

	asc_cfg_s           cfg_q;          // configuration register
	asc_state_e         state_q;        // controller state
	logic [CNT_W-1:0]   cnt_q;          // sampling or conversion count
	logic [2:0]         bit_cnt_q;      // command bits taken
	logic [3:0]         cmd_q;          // command shift register
	logic [3:0]         last_cmd_q;     // last decoded command
	logic               trig_meta_q;    // trigger synchroniser, first stage
	logic               trig_sync_q;    // trigger synchroniser, second stage
	logic               trig_prev_q;    // previous synchronised trigger
	logic               sclk_q;         // previous sclk level
	logic               cs_q;           // previous chip select level
	logic               fs_q;           // previous frame sync level
	logic               trig_pend_q;    // trigger low seen, waiting to sample
	logic               sel_seen_q;     // select nibble seen in this frame
	logic               first_arm_q;    // first repeat sample armed
	logic               ext_mode_q;     // extended sampling active
	logic [1:0]         exit_cnt_q;     // chip selects toward leaving extended mode
	logic               pd_q;           // software power-down
	logic               busy_q;         // end-of-conversion level
	logic               done_n_q;       // done indication, low active
	logic               valid_q;        // unread result held
	logic [RESULT_W-1:0] result_q;      // last result
	logic               push_q;         // result push strobe
	logic [SHIFT_W-1:0] shift_q;        // serial output word
	logic               dp_wr_q;        // write in data phase
	logic [7:0]         dp_addr_q;      // data phase offset
	logic [31:0]        hrdata_q;       // registered read data

	// edge pulses; trigger edges from registered history, pin edges from the live level against the previous one
	logic trig_fall, trig_rise, sclk_rise, sclk_fall, cs_fall, cs_rise, fs_rise, frame_start;
	logic [3:0] cmd_next;
	logic cmd_done, conv_cmd, trig_allowed, single, go_conv, conv_end, enter_x;

	assign trig_fall    = trig_prev_q & ~trig_sync_q;
	assign trig_rise    = ~trig_prev_q & trig_sync_q;
	assign sclk_rise    = pins.sclk & ~sclk_q;
	assign sclk_fall    = ~pins.sclk & sclk_q;
	assign cs_fall      = cs_q & ~pins.chip_select_n;
	assign cs_rise      = ~cs_q & pins.chip_select_n;
	assign fs_rise      = pins.frame_sync & ~fs_q;
	// frame sync starts a frame while chip select stays low
	assign frame_start  = cs_fall | (fs_rise & ~pins.chip_select_n);
	assign cmd_next     = {cmd_q[2:0], pins.serial_in};
	assign cmd_done     = (state_q == ST_CMD) && sclk_rise && (bit_cnt_q == CMD_BITS - 3'h1);
	assign conv_cmd     = is_conv_cmd(cmd_next);
	assign single       = (cfg_q.conv_mode == MODE_SINGLE);
	assign trig_allowed = single | cfg_q.ref_internal;

	// an armed first sample at deselect supersedes a new trigger sample
	assign enter_x = (state_q == ST_IDLE) && !frame_start && !(cs_rise && first_arm_q) &&
		pins.chip_select_n && !trig_sync_q && trig_pend_q && trig_allowed;

	// every way out of sampling into conversion
	always_comb begin
		go_conv = 1'b0;
		case (state_q)
			ST_SAMP_X: go_conv = trig_rise;
			ST_SAMP_F: go_conv = !trig_fall && (cnt_q == FIRST_CYCLES - 8'h01);
			ST_SAMP_N: go_conv = sclk_rise && (cnt_q == samp_len(cfg_q.long_sample) - 8'h01);
			default:   go_conv = 1'b0;
		endcase
	end

	// oscillator conversions count hclk, sclk conversions count sclk edges
	always_comb begin
		conv_end = 1'b0;
		if (state_q == ST_CONV) begin
			if (cfg_q.conv_clk == CLK_OSC) begin
				conv_end = (cnt_q == CONV_OSC_CYCLES - 8'h01);
			end else begin
				conv_end = sclk_rise && (cnt_q == conv_edges(cfg_q.conv_clk) - 8'h01);
			end
		end
	end

	// trigger synchroniser; only the second stage feeds edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_meta_q <= 1'b1;
			trig_sync_q <= 1'b1;
			trig_prev_q <= 1'b1;
		end else begin
			trig_meta_q <= pins.sample_trigger_n;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	// previous pin levels for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			fs_q   <= 1'b0;
		end else begin
			sclk_q <= pins.sclk;
			cs_q   <= pins.chip_select_n;
			fs_q   <= pins.frame_sync;
		end
	end

	// controller state machine; a frame start outside idle is ignored so no conversion is cut
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q   <= ST_IDLE;
			cnt_q     <= '0;
			bit_cnt_q <= '0;
			cmd_q     <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (frame_start) begin
						state_q   <= ST_CMD;
						bit_cnt_q <= '0;
					end else if (cs_rise && first_arm_q) begin
						state_q <= ST_SAMP_F;
						cnt_q   <= '0;
					end else if (enter_x) begin
						state_q <= ST_SAMP_X;
					end
				end
				ST_CMD: begin
					if (cs_rise) begin
						state_q <= ST_IDLE; // frame abandoned
					end else if (sclk_rise) begin
						cmd_q     <= cmd_next;
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (cmd_done) begin
							cnt_q <= '0;
							// extended mode leaves sampling to the trigger
							state_q <= (conv_cmd && !ext_mode_q) ? ST_SAMP_N : ST_IDLE;
						end
					end
				end
				ST_SAMP_N: begin
					if (go_conv) begin
						state_q <= ST_CONV;
						cnt_q   <= '0;
					end else if (sclk_rise) begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_SAMP_X: begin
					if (go_conv) begin
						state_q <= ST_CONV;
						cnt_q   <= '0;
					end
				end
				ST_SAMP_F: begin
					if (trig_fall) begin
						state_q <= ST_SAMP_X; // too short, next trigger takes over
					end else if (go_conv) begin
						state_q <= ST_CONV;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_CONV: begin
					if (conv_end) begin
						state_q <= ST_IDLE;
					end else if ((cfg_q.conv_clk == CLK_OSC) || sclk_rise) begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// pending trigger; a trigger in a repeat select is held until deselect or until the trigger rises
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_pend_q <= 1'b0;
		end else if (trig_fall && (pins.chip_select_n || (cfg_q.conv_mode == MODE_REPEAT && sel_seen_q))) begin
			trig_pend_q <= 1'b1;
		end else if (trig_rise || enter_x || (state_q == ST_SAMP_F && trig_fall)) begin
			trig_pend_q <= 1'b0;
		end
	end

	// select tracking and first-sample arming for repeat with the trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_seen_q  <= 1'b0;
			first_arm_q <= 1'b0;
		end else if (cmd_done && conv_cmd) begin
			sel_seen_q  <= 1'b1;
			first_arm_q <= ext_mode_q && (cfg_q.conv_mode == MODE_REPEAT) && trig_allowed;
		end else if (frame_start || cs_rise) begin
			sel_seen_q  <= 1'b0;
			first_arm_q <= 1'b0;
		end
	end

	// extended mode: entered by a trigger sample, left after two clean chip selects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_mode_q <= 1'b0;
			exit_cnt_q <= '0;
		end else if (enter_x) begin
			ext_mode_q <= 1'b1; // entry wins over a coincident exit
			exit_cnt_q <= '0;
		end else if (ext_mode_q && cs_fall && trig_sync_q) begin
			if (exit_cnt_q == 2'h1) begin
				ext_mode_q <= 1'b0;
				exit_cnt_q <= '0;
			end else begin
				exit_cnt_q <= exit_cnt_q + 2'h1;
			end
		end
	end

	// last command and software power-down; non-select commands act even in dummy use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_cmd_q <= '0;
			pd_q       <= 1'b0;
		end else if (cmd_done) begin
			last_cmd_q <= cmd_next;
			if (cmd_next == CMD_POWER_DOWN) begin
				pd_q <= 1'b1;
			end else if (conv_cmd) begin
				pd_q <= 1'b0;
			end
		end
	end

	// end-of-conversion level in single shot with eoc_select, done indication in every other case
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q   <= 1'b0;
			done_n_q <= 1'b1;
		end else begin
			if (go_conv) begin
				busy_q <= single && cfg_q.eoc_select;
			end else if (conv_end) begin
				busy_q <= 1'b0;
			end
			// done stays low until the host starts its next frame
			if (conv_end && !(single && cfg_q.eoc_select)) begin
				done_n_q <= 1'b0;
			end else if (frame_start) begin
				done_n_q <= 1'b1;
			end
		end
	end

	// result capture; fifo modes push every result, single shot bypasses the fifo
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_q <= '0;
			valid_q  <= 1'b0;
			push_q   <= 1'b0;
		end else begin
			push_q <= conv_end && !single;
			if (conv_end) begin
				result_q <= conv_data;
				valid_q  <= 1'b1; // a new result wins over a consuming read
			end else if (cmd_done && (conv_cmd || cmd_next == CMD_READ_FIFO)) begin
				valid_q <= 1'b0;
			end
		end
	end

	// serial output word, msb first, shifted on sclk falling edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= '0;
		end else if (frame_start) begin
			shift_q <= valid_q ? {result_q, {(SHIFT_W-RESULT_W){1'b0}}} : '0;
		end else if (cmd_done && cmd_next == CMD_READ_CFG && single) begin
			shift_q <= {cfg_q, 4'h0}; // configuration readback, single shot only
		end else if (sclk_fall && !pins.chip_select_n) begin
			shift_q <= {shift_q[SHIFT_W-2:0], 1'b0};
		end
	end

	// ahb-lite address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= '0;
		end else if (hready) begin
			dp_wr_q   <= hsel && htrans[1] && hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	// configuration write; kept across sequences until software rewrites it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= asc_cfg_s'(CFG_RESET);
		end else if (dp_wr_q && dp_addr_q == ADDR_CONFIG) begin
			cfg_q <= asc_cfg_s'(hwdata[11:0]);
		end
	end

	// read data registered in the address phase; a write just ahead is forwarded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_q <= '0;
			case (haddr[7:0])
				ADDR_CONFIG: hrdata_q[11:0] <= (dp_wr_q && dp_addr_q == ADDR_CONFIG) ? hwdata[11:0] : cfg_q;
				ADDR_STATUS: begin
					hrdata_q[5:0]          <= state_q;
					hrdata_q[ST_BUSY_BIT]  <= busy_q;
					hrdata_q[ST_PD_BIT]    <= pd_q;
					hrdata_q[ST_EXT_BIT]   <= ext_mode_q;
					hrdata_q[ST_VALID_BIT] <= valid_q;
				end
				ADDR_RESULT: hrdata_q[RESULT_W-1:0] <= result_q;
				ADDR_CMD:    hrdata_q[3:0] <= last_cmd_q;
				default:     hrdata_q <= '0; // unmapped reads zero
			endcase
		end
	end

	// zero wait state slave, always okay; hsize is accepted as a word
	assign hreadyout            = 1'b1;
	assign hresp                = 1'b0;
	assign hrdata               = hrdata_q;
	assign serial_out           = shift_q[SHIFT_W-1];
	assign conversion_busy_flag = busy_q;
	assign done_interrupt_n     = done_n_q;
	assign sample_hold          = state_q[2] | state_q[3] | state_q[4];
	assign result_push          = push_q;
	assign result_data          = result_q;
	assign powered_down         = pd_q;

endmodule
`default_nettype wire

//--- asc_props.sv
// checker: port assertions for the sample and convert controller
`timescale 1ns/1ns
`default_nettype none
module asc_props #(
	parameter int unsigned RESULT_W = 10
) (
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire asc_pkg::asc_pins_s  pins,
	input wire logic                conversion_busy_flag,
	input wire logic                done_interrupt_n,
	input wire logic                sample_hold,
	input wire logic                result_push,
	input wire logic [RESULT_W-1:0] result_data
);
	import asc_pkg::*;
	logic       sclk_q;  // sclk one hclk ago
	logic [7:0] samp_q;  // sclk rises inside the sampling window
	logic [7:0] cmd_q;   // sclk rises since the frame began
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// rise counters; a frame restarts on deselect or on a frame pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 1'b0;
			samp_q <= 8'h00;
			cmd_q  <= 8'h00;
		end else begin
			sclk_q <= pins.sclk;
			if (!sample_hold) begin
				samp_q <= 8'h00;
			end else if (pins.sclk && !sclk_q) begin
				samp_q <= samp_q + 8'h01;
			end
			if (pins.chip_select_n || pins.frame_sync) begin
				cmd_q <= 8'h00;
			end else if (pins.sclk && !sclk_q) begin
				cmd_q <= cmd_q + 8'h01;
			end
		end
	end
	// zero-wait slave, never an error answer
	a_bus_always_ok: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
	a_cmd_first: assert property ($rose(sample_hold) && !pins.chip_select_n
		|-> cmd_q == 8'h04) else $error("sampling began off the fourth bit");
	a_sample_count: assert property ($fell(sample_hold) && !pins.chip_select_n
		|-> samp_q == SHORT_SCLKS || samp_q == LONG_SCLKS) else $error("sampling length wrong");
	a_busy_from_sample: assert property ($rose(conversion_busy_flag)
		|-> $past(sample_hold) || $past(sample_hold, 2)) else $error("busy without sampling");
	a_busy_holds: assert property ($rose(conversion_busy_flag)
		|=> conversion_busy_flag [*8]) else $error("busy too short");
	a_conv_in_time: assert property ($fell(sample_hold) && done_interrupt_n
		|-> ##[1:80] (!done_interrupt_n || $fell(conversion_busy_flag))) else $error("conversion too long");
	a_trig_ends_sample: assert property (sample_hold && pins.chip_select_n
		&& $rose(pins.sample_trigger_n) |-> ##[1:5] !sample_hold) else $error("trigger rise kept sampling");
	a_push_single: assert property (result_push |=> !result_push) else $error("push longer than one cycle");
	a_push_with_done: assert property ($rose(result_push)
		|-> !done_interrupt_n ##1 $stable(result_data)) else $error("push without finished result");
	a_no_busy_sampling: assert property (!(sample_hold && conversion_busy_flag))
		else $error("busy while sampling");
	// main scenarios reached
	c_long_sample: cover property ($fell(sample_hold) && samp_q == LONG_SCLKS);
	c_ext_sample: cover property ($rose(sample_hold) && pins.chip_select_n);
	c_busy_end: cover property ($fell(conversion_busy_flag));
	c_push: cover property (result_push);
endmodule
bind asc_top asc_props #(.RESULT_W(RESULT_W)) i_asc_props (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
	.conversion_busy_flag(conversion_busy_flag), .done_interrupt_n(done_interrupt_n),
	.sample_hold(sample_hold), .result_push(result_push), .result_data(result_data));
`default_nettype wire

//--- asc_host.sv
// host serial port model driving the converter's pins
`timescale 1ns/1ns
`default_nettype none
module asc_host #(
	parameter int unsigned MIN_LOW = 20  // least trigger low time, hclk cycles
) (
	input  wire logic              hclk,
	input  wire logic              serial_out,
	output var asc_pkg::asc_pins_s pins,
	output logic [15:0]            rx_word
);
	import asc_pkg::*;
	// idle: deselected, sclk parked low, trigger high
	initial begin
		pins = '{sclk: 1'b0, chip_select_n: 1'b1, frame_sync: 1'b0, serial_in: 1'b0, sample_trigger_n: 1'b1};
		rx_word = 16'h0000;
	end
	// sclk at hclk/4, 5 MHz, slow enough for short sampling
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge hclk);
			pins.sclk <= 1'b1;
			rx_word <= {rx_word[14:0], serial_out};
			repeat (2) @(posedge hclk);
			pins.sclk <= 1'b0;
			@(posedge hclk);
		end
	endtask
	// select, then the command nibble msb first
	task automatic frame_start(input logic [3:0] cmd);
		@(posedge hclk);
		pins.chip_select_n <= 1'b0;
		for (int i = 3; i >= 0; i--) begin
			@(posedge hclk);
			pins.serial_in <= cmd[i];
			pulse(1);
		end
	endtask
	// deselect; the released data line stops showing its last level
	task automatic frame_end();
		@(posedge hclk);
		pins.chip_select_n <= 1'b1;
		pins.serial_in <= ~pins.serial_in;
	endtask
	// dsp style frame pulse; chip select is left where it stands
	task automatic sync_pulse();
		@(posedge hclk);
		pins.frame_sync <= 1'b1;
		@(posedge hclk);
		pins.frame_sync <= 1'b0;
	endtask
	// triggers only between frames, never mixed into one
	task automatic trigger(input int low);
		if (low < MIN_LOW) low = MIN_LOW;
		@(posedge hclk);
		pins.sample_trigger_n <= 1'b0;
		repeat (low) @(posedge hclk);
		pins.sample_trigger_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- adc_sample_convert_control_test.sv
// self-checking bench for the sample and convert controller
`timescale 1ns/1ns
`default_nettype none
module adc_sample_convert_control_test;
	import asc_pkg::*;
	logic        hclk = 1'b0;     // 20 MHz
	logic        hresetn = 1'b0;  // low for three cycles
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  hsize = 3'h0;
	logic [9:0]  cdata = 10'h2a5;  // analog core result, changed once to prove capture
	logic [31:0] hrdata, rd_v;
	logic        hreadyout, hresp, sout, busy, done_n, samp, push, pd;
	logic        sclk_q, done_q, samp_q;
	logic [9:0]  res;
	asc_pins_s   pins;
	logic [15:0] rx_word;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          rises = 0;     // sclk rises while sampling
	int          n_samp = 0;    // sampling windows begun
	int          n_push = 0;    // results pushed
	int          since = 0;     // cycles since sampling ended
	int          conv_len = 0;  // sampling end to done low
	int          s0, p0, r0;
	asc_top i_asc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pins(pins), .conv_data(cdata), .serial_out(sout),
		.conversion_busy_flag(busy), .done_interrupt_n(done_n), .sample_hold(samp),
		.result_push(push), .result_data(res), .powered_down(pd));
	asc_host i_asc_host (.hclk(hclk), .serial_out(sout), .pins(pins), .rx_word(rx_word));
	initial forever #25 hclk = ~hclk;
	// counters other than since only grow; tests compare snapshots so nothing races a clear
	always @(posedge hclk) begin
		sclk_q <= pins.sclk;
		done_q <= done_n;
		samp_q <= samp;
		if (samp && pins.sclk && !sclk_q) rises <= rises + 1;
		if (samp && !samp_q) n_samp <= n_samp + 1;
		if (push) n_push <= n_push + 1;
		since <= samp ? 0 : since + 1;
		if (done_q && !done_n) conv_len <= since;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, rd_v);
		check(what, rd_v & m, e);
	endtask
	// whole frame, then room for the 77 cycle conversion
	task automatic frame(input logic [3:0] c, input int n);
		i_asc_host.frame_start(c);
		i_asc_host.pulse(n);
		i_asc_host.frame_end();
		repeat (100) @(posedge hclk);
	endtask
	task automatic trig();
		i_asc_host.trigger(30);
		repeat (100) @(posedge hclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("config", ADDR_CONFIG, 32'hfff, 32'h0);
		rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
		ahb(1'b1, ADDR_CONFIG, 32'h284, rd_v);
		rdc("config", ADDR_CONFIG, 32'hfff, 32'h284);
		ahb(1'b1, ADDR_CONFIG, 32'h0, rd_v);
		$display("register test done");
		// every command code; only channel and test codes sample
		for (int c = 0; c < 16; c++) begin
			r0 = rises;
			frame(4'(c), 12);
			check("rises", 32'(rises - r0), (c < 8 || (c > 10 && c < 14)) ? 32'hc : 32'h0);
			check("powered", {31'h0, pd}, {31'h0, c > 7 && c < 11});
			if (c == 8) check("word", {16'h0, rx_word}, 32'ha940);
		end
		check("conv time", 32'(conv_len > 74 && conv_len < 80), 32'h1);
		check("result", {22'h0, res}, 32'h2a5);
		check("pushes", 32'(n_push), 32'h0);
		$display("command test done");
		ahb(1'b1, ADDR_CONFIG, 32'h284, rd_v);
		r0 = rises;
		i_asc_host.frame_start(4'h2);
		i_asc_host.pulse(37);
		check("long rises", 32'(rises - r0), 32'h18);
		check("busy 13", {31'h0, busy}, 32'h1);
		i_asc_host.pulse(1);
		repeat (2) @(posedge hclk);
		check("busy 14", {31'h0, busy}, 32'h0);
		check("done pin", {31'h0, done_n}, 32'h1);
		i_asc_host.frame_end();
		$display("sclk conversion test done");
		ahb(1'b1, ADDR_CONFIG, 32'h0, rd_v);
		s0 = n_samp;
		trig();
		check("ext", 32'(n_samp - s0), 32'h1);
		rdc("ext flag", ADDR_STATUS, 32'h400, 32'h400);
		ahb(1'b1, ADDR_CONFIG, 32'h020, rd_v);
		trig();
		check("ext refused", 32'(n_samp - s0), 32'h1);
		ahb(1'b1, ADDR_CONFIG, 32'h820, rd_v);
		p0 = n_push;
		cdata <= 10'h15a;
		trig();
		check("ext repeat", 32'(n_samp - s0), 32'h2);
		check("push", 32'(n_push - p0), 32'h1);
		check("ext result", {22'h0, res}, 32'h15a);
		ahb(1'b1, ADDR_CONFIG, 32'h0, rd_v);
		frame(4'h0, 12);
		check("ext word", {16'h0, rx_word}, 32'h5680);
		check("ext select", 32'(n_samp - s0), 32'h2);
		rdc("ext flag", ADDR_STATUS, 32'h400, 32'h400);
		frame(4'h9, 12);
		rdc("ext flag", ADDR_STATUS, 32'h400, 32'h0);
		r0 = rises;
		frame(4'h3, 12);
		check("normal", 32'(rises - r0), 32'hc);
		// second frame started by a frame pulse while chip select stays low
		i_asc_host.frame_start(4'h3);
		i_asc_host.pulse(12);
		repeat (100) @(posedge hclk);
		r0 = rises;
		i_asc_host.sync_pulse();
		i_asc_host.frame_start(4'h3);
		i_asc_host.pulse(12);
		check("sync rises", 32'(rises - r0), 32'hc);
		i_asc_host.frame_end();
		repeat (100) @(posedge hclk);
		$display("extended test done");
		end_of_test();
	end
	// a hang is cut short well past the expected run
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
